// file: hw/urb_cts_detect.sv
// clear-to-send filter and change detector
`default_nettype none
module urb_cts_detect
  import urb_pkg::*;
#(
  parameter int FILTER_CYC = COS_FILTER_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic serialTick,
  input  wire logic ctsIn_n,
  output logic      ctsLevel,
  output logic      ctsValid,
  output logic      changePulse
);
  logic [12:0] filtCnt;
  logic [12:0] next_filtCnt;
  logic [1:0]  startCnt;
  logic [1:0]  next_startCnt;
  logic        next_ctsLevel;
  logic        next_ctsValid;
  logic        next_changePulse;

  always_comb begin
    next_filtCnt = filtCnt;
    next_startCnt = startCnt;
    next_ctsLevel = ctsLevel;
    next_ctsValid = ctsValid;
    next_changePulse = 1'b0;
    if (!ctsValid) begin
      if (serialTick) begin
        next_startCnt = 2'(startCnt + 2'h1);
        if (startCnt == 2'(CTS_START_TICKS - 1)) begin
          next_ctsValid = 1'b1;
          next_ctsLevel = ctsIn_n;
          next_changePulse = !ctsIn_n; // [R15]
        end
      end
    end else if (ctsIn_n == ctsLevel) begin
      next_filtCnt = '0;
    end else if (filtCnt == 13'(FILTER_CYC - 1)) begin
      next_filtCnt = '0;
      next_ctsLevel = ctsIn_n;
      next_changePulse = 1'b1; // [R12]
    end else begin
      next_filtCnt = 13'(filtCnt + 13'h1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      filtCnt <= '0;
      startCnt <= '0;
      ctsLevel <= 1'b1;
      ctsValid <= 1'b0;
      changePulse <= 1'b0;
    end else begin
      filtCnt <= next_filtCnt;
      startCnt <= next_startCnt;
      ctsLevel <= next_ctsLevel;
      ctsValid <= next_ctsValid;
      changePulse <= next_changePulse;
    end
  end

  AST_CTS_FOLLOWS: assert property (@(posedge ref_clk) disable iff (rst)
    (ctsValid && changePulse) |-> ctsLevel == $past(ctsIn_n)) // [R12]
    else $error("filtered level not taken from input");
endmodule
`default_nettype wire

// file: hw/urb_pkg.sv
// register map, field positions and timing constants of the serial port block
`default_nettype none
package urb_pkg;
  localparam logic [7:0] OFS_COMMAND      = 8'h00;
  localparam logic [7:0] OFS_RX_BUFFER    = 8'h04;
  localparam logic [7:0] OFS_TX_BUFFER    = 8'h08;
  localparam logic [7:0] OFS_INPUT_CHANGE = 8'h0C;
  localparam logic [7:0] OFS_AUX_CONTROL  = 8'h10;
  localparam logic [7:0] OFS_INT_STATUS   = 8'h14;
  localparam logic [7:0] OFS_INT_MASK     = 8'h18;
  localparam logic [7:0] OFS_MODE         = 8'h1C;
  localparam logic [7:0] OFS_LINE_STATUS  = 8'h20;
  localparam logic [7:0] OFS_BAUD_DIV     = 8'h24;
  localparam int RC_LSB        = 0;
  localparam int TC_LSB        = 2;
  localparam logic [1:0] CMD_NONE    = 2'h0;
  localparam logic [1:0] CMD_ENABLE  = 2'h1;
  localparam logic [1:0] CMD_DISABLE = 2'h2;
  localparam logic [1:0] PM_MULTIDROP = 2'h3;
  localparam int MODE_PM_LSB   = 3;
  localparam int MODE_LOOP_BIT = 7;
  localparam int COS_BIT       = 4;
  localparam int CTS_BIT       = 0;
  localparam int IEC_BIT       = 0;
  localparam int IS_COS        = 7;
  localparam int IS_RXRDY      = 1;
  localparam int IS_TRANSMITTER_READY      = 0;
  localparam int LS_TXEMP      = 3;
  localparam int LS_FFULL      = 1;
  localparam int LS_RXRDY      = 0;
  localparam int LS_TRANSMITTER_READY      = 2;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0002;
  localparam int CLK_MHZ       = 100;
  localparam int COS_FILTER_US = 25;
  localparam int COS_FILTER_CYC = COS_FILTER_US * CLK_MHZ;
  localparam int CTS_START_TICKS = 2;
  localparam int OVERSAMPLE    = 16;
endpackage
`default_nettype wire

// file: hw/urb_rx_fifo.sv
// three-entry receive holding queue
`default_nettype none
module urb_rx_fifo
  import urb_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             pushValid,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             popReady,
  output logic                  popValid,
  output logic [WIDTH-1:0]      popData,
  output logic                  full
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [1:0]       count;
  logic [1:0]       next_count;
  logic             doPop;
  logic             doPush;

  always_comb begin
    doPop  = popReady && (count != 2'h0);
    doPush = pushValid && (!full || doPop);
    next_mem = mem;
    next_count = count;
    if (doPop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_mem[i] = mem[i + 1];
      end
    end
    if (doPush) begin
      next_mem[2'(count - (doPop ? 2'h1 : 2'h0))] = pushData;
    end
    next_count = 2'(count + (doPush ? 2'h1 : 2'h0) - (doPop ? 2'h1 : 2'h0));
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= 2'h0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      count <= next_count;
      mem   <= next_mem;
    end
  end

  assign popValid = (count != 2'h0);
  assign popData  = mem[0];
  assign full     = (count == 2'(DEPTH));

  AST_FIFO_NO_OVER: assert property (@(posedge ref_clk) disable iff (rst)
    count <= 2'(DEPTH)) else $error("receive queue count above depth"); // [R06]
  AST_FIFO_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
    (doPop && count > 2'h1) |=> popData == $past(mem[1])) // [R07]
    else $error("oldest entry not presented after pop");
endmodule
`default_nettype wire

// file: hw/urb_uart_top.sv
// serial port receiver control, receive queue, transmit buffer and CTS change logic
// Behaviour
// [R01] receiver command 00 leaves receiver enable unchanged
// [R02] command 01 enables receiver, searches start bit, unless multidrop parity mode
// [R03] command 10 disables receiver at once, drops partial character, keeps status
// [R04] loop-back or multidrop keeps receiver running despite disable
// [R05] software never writes reserved receiver command 11
// [R06] receive path: one shift register and three-entry queue
// [R07] reads return oldest queue entry; full shift register pushes at bottom
// [R08] transmit holding register accepts characters only while transmitter ready
// [R09] transmit write clears transmitter ready
// [R10] empty shift register loads pending character and sets ready again; a write in the cycle a frame ends is never loaded and ready stays low
// [R11] transmit writes ignored when not ready or transmitter disabled
// [R12] change bit set when CTS changes and holds past filter time
// [R13] reading input change register clears change bit and status change bit
// [R14] bit 0 shows CTS level, valid two serial clocks after reset
// [R15] CTS asserted at first sample after reset sets change bit
// [R16] aux control bit 0 routes change event to interrupt status
// [R17] software writes zeros to reserved bits of change and aux registers
// [R18] interrupt output high while status and mask bits both set
`default_nettype none
module urb_uart_top
  import urb_pkg::*;
#(
  parameter int DATA_W     = 8,
  parameter int FIFO_DEPTH = 3,
  parameter int FILTER_CYC = COS_FILTER_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        serialRxPin,
  output logic             serialTxPin,
  input  wire logic        clearToSendIn_n,
  output logic             irq
);
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_SHIFT = 3'b010,
    RX_STOP  = 3'b100
  } urb_rx_e;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } urb_tx_e;

  // bus slave address phase capture
  logic        wrPend;
  logic [7:0]  addrPend;
  logic        next_wrPend;
  logic [7:0]  next_addrPend;
  logic        wrEn, rdEn;
  logic [7:0]  wrData;

  // registers
  logic        rxEnabled, txEnabled, txReady, txEmpty, cosFlag;
  logic [7:0]  modeReg, auxCtrl, intStatus, intMask;
  logic [15:0] baudDiv;
  logic [7:0]  txHold, txShift;
  logic        next_rxEnabled, next_txEnabled, next_txReady, next_txEmpty, next_cosFlag;
  logic [7:0]  next_modeReg, next_auxCtrl, next_intStatus, next_intMask;
  logic [15:0] next_baudDiv;
  logic [7:0]  next_txHold, next_txShift;
  logic [31:0] next_hrdata;

  // baud divider: one tick per oversample slot
  logic [15:0] baudCnt, next_baudCnt;
  logic        serialTick;

  // receiver
  urb_rx_e     rxState, next_rxState;
  logic [3:0]  rxSub, next_rxSub;
  logic [2:0]  rxBit, next_rxBit;
  logic [7:0]  rxShift, next_rxShift;
  logic        rxPush;
  logic        rxRun, multidrop, loopback, lineIn;

  // transmitter
  urb_tx_e     txState, next_txState;
  logic [3:0]  txSub, next_txSub;
  logic [3:0]  txBit, next_txBit;
  logic        next_serialTxPin;

  // queue and CTS
  logic        fifoValid, fifoFull, fifoPop;
  logic [7:0]  fifoData;
  logic        ctsLevel, ctsValid, ctsChange;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wrEn   = wrPend;
  assign wrData = hwdata[7:0];
  assign rdEn   = hsel && hready && htrans[1] && !hwrite;

  assign multidrop = (modeReg[MODE_PM_LSB +: 2] == PM_MULTIDROP);
  assign loopback  = modeReg[MODE_LOOP_BIT];
  assign rxRun     = rxEnabled || loopback || multidrop; // [R04]
  assign lineIn    = loopback ? serialTxPin : serialRxPin;
  assign serialTick = (baudCnt == 16'h0001);
  assign fifoPop   = rdEn && (haddr[7:0] == OFS_RX_BUFFER); // [R07]

  always_comb begin
    next_wrPend   = hsel && hready && htrans[1] && hwrite;
    next_addrPend = (hsel && hready && htrans[1]) ? haddr[7:0] : addrPend;
  end

  always_comb begin
    next_baudCnt = (baudCnt <= 16'h0001) ? baudDiv : 16'(baudCnt - 16'h0001);
  end

  // receiver: 16x oversampled, mid-bit sampling
  always_comb begin
    next_rxState = rxState;
    next_rxSub   = rxSub;
    next_rxBit   = rxBit;
    next_rxShift = rxShift;
    rxPush       = 1'b0;
    if (!rxRun) begin
      next_rxState = RX_IDLE; // [R03]
      next_rxSub   = '0;
    end else if (serialTick) begin
      unique case (rxState)
        RX_IDLE: begin
          if (!lineIn) begin
            next_rxSub = 4'(rxSub + 4'h1);
            if (rxSub == 4'(OVERSAMPLE / 2 - 1)) begin
              next_rxState = RX_SHIFT;
              next_rxSub = '0;
              next_rxBit = '0;
            end
          end else begin
            next_rxSub = '0;
          end
        end
        RX_SHIFT: begin
          next_rxSub = 4'(rxSub + 4'h1);
          if (rxSub == 4'(OVERSAMPLE - 1)) begin
            next_rxShift = {lineIn, rxShift[7:1]}; // [R06]
            next_rxBit = 3'(rxBit + 3'h1);
            if (rxBit == 3'h7) begin
              next_rxState = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          next_rxSub = 4'(rxSub + 4'h1);
          if (rxSub == 4'(OVERSAMPLE - 1)) begin
            next_rxState = RX_IDLE;
            next_rxSub = '0;
            rxPush = 1'b1; // [R07]
          end
        end
      endcase
    end
  end

  // transmitter shift register and holding register hand-off
  always_comb begin
    next_txState = txState;
    next_txSub   = txSub;
    next_txBit   = txBit;
    next_txShift = txShift;
    next_serialTxPin = serialTxPin;
    next_txReady = txReady;
    next_txEmpty = txEmpty;
    next_txHold  = txHold;
    if (wrEn && addrPend == OFS_TX_BUFFER && txReady && txEnabled) begin // [R11]
      next_txHold  = wrData; // [R08]
      next_txReady = 1'b0; // [R09]
      next_txEmpty = 1'b0;
    end
    unique case (txState)
      TX_IDLE: begin
        next_serialTxPin = 1'b1;
        if (!txReady && txEnabled && !txEmpty) begin
          next_txShift = txHold; // [R10]
          next_txReady = 1'b1; // [R10]
          next_txState = TX_SHIFT;
          next_txSub = '0;
          next_txBit = '0;
          next_serialTxPin = 1'b0;
        end
      end
      TX_SHIFT: begin
        if (serialTick) begin
          next_txSub = 4'(txSub + 4'h1);
          if (txSub == 4'(OVERSAMPLE - 1)) begin
            next_txBit = 4'(txBit + 4'h1);
            if (txBit == 4'h9) begin
              next_txState = TX_IDLE;
              next_txEmpty = txReady;
            end else if (txBit == 4'h8) begin
              next_serialTxPin = 1'b1;
            end else begin
              next_serialTxPin = txShift[txBit[2:0]];
            end
          end
        end
      end
    endcase
    if (!txEnabled) begin
      // enabling frees holding and shift register, so nothing stale is sent
      next_txReady = wrEn && addrPend == OFS_COMMAND && wrData[TC_LSB +: 2] == CMD_ENABLE;
      next_txEmpty = next_txReady;
    end
  end

  // register writes, commands, interrupt status
  always_comb begin
    next_rxEnabled = rxEnabled;
    next_txEnabled = txEnabled;
    next_modeReg   = modeReg;
    next_auxCtrl   = auxCtrl;
    next_intMask   = intMask;
    next_baudDiv   = baudDiv;
    next_cosFlag   = cosFlag;
    next_intStatus = intStatus;
    if (wrEn) begin
      unique case (addrPend)
        OFS_COMMAND: begin
          unique case (wrData[RC_LSB +: 2])
            CMD_ENABLE: begin
              if (!multidrop) begin
                next_rxEnabled = 1'b1; // [R02]
              end
            end
            CMD_DISABLE: next_rxEnabled = 1'b0; // [R03]
            default: next_rxEnabled = rxEnabled; // [R01]
          endcase
          if (wrData[TC_LSB +: 2] == CMD_ENABLE) begin
            next_txEnabled = 1'b1;
          end else if (wrData[TC_LSB +: 2] == CMD_DISABLE) begin
            next_txEnabled = 1'b0;
          end
        end
        OFS_AUX_CONTROL: next_auxCtrl = {7'h00, wrData[IEC_BIT]};
        OFS_INT_MASK:    next_intMask = wrData;
        OFS_MODE:        next_modeReg = wrData;
        OFS_BAUD_DIV:    next_baudDiv = hwdata[15:0];
        default:         next_intMask = intMask;
      endcase
    end
    if (rdEn && haddr[7:0] == OFS_INPUT_CHANGE) begin
      next_cosFlag = 1'b0; // [R13]
      next_intStatus[IS_COS] = 1'b0; // [R13]
    end else if (rdEn && haddr[7:0] == OFS_INT_STATUS) begin
      next_intStatus[IS_COS] = 1'b0;
    end
    if (ctsChange) begin
      next_cosFlag = 1'b1; // [R12]
      if (auxCtrl[IEC_BIT]) begin
        next_intStatus[IS_COS] = 1'b1; // [R16]
      end
    end
    next_intStatus[IS_RXRDY] = fifoValid;
    next_intStatus[IS_TRANSMITTER_READY] = next_txReady;
  end

  always_comb begin
    next_hrdata = '0;
    if (rdEn) begin
      unique case (haddr[7:0])
        OFS_RX_BUFFER:    next_hrdata = {24'h0, fifoData};
        OFS_INPUT_CHANGE: next_hrdata = {27'h0, cosFlag, 3'h0, ctsLevel}; // [R14]
        OFS_AUX_CONTROL:  next_hrdata = {24'h0, auxCtrl};
        OFS_INT_STATUS:   next_hrdata = {24'h0, intStatus};
        OFS_MODE:         next_hrdata = {24'h0, modeReg};
        OFS_LINE_STATUS:  next_hrdata = {28'h0, txEmpty, txReady, fifoFull, fifoValid};
        default:          next_hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPend <= 1'b0;
      addrPend <= '0;
      baudCnt <= BAUD_DIV_RESET;
      rxState <= RX_IDLE;
      rxSub <= '0;
      rxBit <= '0;
      rxShift <= '0;
      txState <= TX_IDLE;
      txSub <= '0;
      txBit <= '0;
      txShift <= '0;
      txHold <= '0;
      serialTxPin <= 1'b1;
      txReady <= 1'b0;
      txEmpty <= 1'b0;
      rxEnabled <= 1'b0;
      txEnabled <= 1'b0;
      modeReg <= '0;
      auxCtrl <= '0;
      intMask <= '0;
      intStatus <= '0;
      baudDiv <= BAUD_DIV_RESET;
      cosFlag <= 1'b0;
      hrdata <= '0;
    end else begin
      wrPend <= next_wrPend;
      addrPend <= next_addrPend;
      baudCnt <= next_baudCnt;
      rxState <= next_rxState;
      rxSub <= next_rxSub;
      rxBit <= next_rxBit;
      rxShift <= next_rxShift;
      txState <= next_txState;
      txSub <= next_txSub;
      txBit <= next_txBit;
      txShift <= next_txShift;
      txHold <= next_txHold;
      serialTxPin <= next_serialTxPin;
      txReady <= next_txReady;
      txEmpty <= next_txEmpty;
      rxEnabled <= next_rxEnabled;
      txEnabled <= next_txEnabled;
      modeReg <= next_modeReg;
      auxCtrl <= next_auxCtrl;
      intMask <= next_intMask;
      intStatus <= next_intStatus;
      baudDiv <= next_baudDiv;
      cosFlag <= next_cosFlag;
      hrdata <= next_hrdata;
    end
  end

  assign irq = |(intStatus & intMask); // [R18]

  urb_rx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxQueue (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pushValid (rxPush),
    .pushData  (rxShift),
    .popReady  (fifoPop),
    .popValid  (fifoValid),
    .popData   (fifoData),
    .full      (fifoFull)
  );

  urb_cts_detect #(.FILTER_CYC(FILTER_CYC)) ctsDetect (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .serialTick  (serialTick),
    .ctsIn_n     (clearToSendIn_n),
    .ctsLevel    (ctsLevel),
    .ctsValid    (ctsValid),
    .changePulse (ctsChange)
  );

  sequence s_cmdWrite(logic [1:0] code);
    wrEn && addrPend == OFS_COMMAND && wrData[RC_LSB +: 2] == code;
  endsequence

  AST_RC_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [R01]
    s_cmdWrite(CMD_NONE) |=> rxEnabled == $past(rxEnabled))
    else $error("no-action command changed receiver state");
  AST_RC_ENABLE: assert property (@(posedge ref_clk) disable iff (rst) // [R02]
    (s_cmdWrite(CMD_ENABLE) and !multidrop) |=> rxEnabled)
    else $error("receiver not enabled");
  AST_RC_DISABLE: assert property (@(posedge ref_clk) disable iff (rst) // [R03]
    s_cmdWrite(CMD_DISABLE) |=> !rxEnabled)
    else $error("receiver not disabled");
  AST_RX_KEEP: assert property (@(posedge ref_clk) disable iff (rst) // [R04]
    (loopback || multidrop) |-> rxRun)
    else $error("receiver stopped in loop-back or multidrop");
  AST_TX_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // [R09]
    (wrEn && addrPend == OFS_TX_BUFFER && txReady && txEnabled && txState == TX_SHIFT)
    |=> !txReady)
    else $error("transmit write did not clear ready");
  AST_TX_IGNORE: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    (wrEn && addrPend == OFS_TX_BUFFER && !(txReady && txEnabled)) |=> $stable(txHold))
    else $error("ignored transmit write altered buffer");
  AST_TX_LOAD: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    (txState == TX_IDLE && txEnabled && !txReady && !txEmpty)
    |=> txState == TX_SHIFT && txShift == $past(txHold) && txReady)
    else $error("pending character not loaded");
  AST_COS_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
    (rdEn && haddr[7:0] == OFS_INPUT_CHANGE && !ctsChange) |=> !cosFlag && !intStatus[IS_COS])
    else $error("read did not clear change flags");
  AST_COS_ROUTE: assert property (@(posedge ref_clk) disable iff (rst) // [R16]
    (ctsChange && !auxCtrl[IEC_BIT] && !intStatus[IS_COS]) |=> !intStatus[IS_COS])
    else $error("change routed with input enable clear");
  AST_IRQ: assert property (@(posedge ref_clk) disable iff (rst) // [R18]
    irq == |(intStatus & intMask))
    else $error("interrupt output wrong");
endmodule
`default_nettype wire

// file: tb/uart_rx_tx_buffers_cts_change_bench.sv
// self-checking bench of the serial port block
`default_nettype none
module uart_rx_tx_buffers_cts_change_bench
  import urb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        rxPin;
  logic        txPin;
  logic        ctsN;
  logic        irq;
  int          nErrors;
  int          checks;
  logic [7:0]  b;
  logic [7:0]  c;
  logic [7:0]  rxq[$];
  logic [7:0]  txq[$];

  urb_uart_top #(.FILTER_CYC(20)) dut (
    .ref_clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .serialRxPin(rxPin),
    .serialTxPin(txPin), .clearToSendIn_n(ctsN), .irq(irq)
  );
  urb_serial_peer peer (.ref_clk(clk), .rxLine(rxPin), .txLine(txPin));

  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %s exp=%h got=%h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    // no wait limit: the watchdog ends a hung transfer
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                       input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, r & m, e);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    nErrors++;
    tally_and_finish();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ctsN = 1'b1;
    nErrors = 0;
    checks = 0;
    void'($urandom(32'hAA05));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk("irq_reset", {31'h0, irq}, 32'h0);
    rdchk(OFS_INPUT_CHANGE, 32'h01, 32'hFF, "ipc_idle");
    $display("test reset done");
    // three characters fill the queue, read back oldest first
    wr(OFS_COMMAND, {30'h0, CMD_ENABLE});
    repeat (3) begin
      b = 8'($urandom);
      rxq.push_back(b);
      peer.send(b);
    end
    repeat (40) @(posedge clk);
    rdchk(OFS_LINE_STATUS, 32'h3, 32'h3, "ls_full");
    repeat (3) rdchk(OFS_RX_BUFFER, {24'h0, rxq.pop_front()}, 32'hFF, "rxbuf");
    $display("test rx_queue done");
    // disable in mid-character, then no-op command keeps it off
    b = 8'($urandom);
    fork
      peer.send(b);
      begin
        repeat (100) @(posedge clk);
        wr(OFS_COMMAND, {30'h0, CMD_DISABLE});
      end
    join
    wr(OFS_COMMAND, {30'h0, CMD_NONE});
    peer.send(b);
    repeat (40) @(posedge clk);
    rdchk(OFS_LINE_STATUS, 32'h0, 32'h1, "rx_off");
    wr(OFS_COMMAND, {30'h0, CMD_ENABLE});
    wr(OFS_COMMAND, {30'h0, CMD_NONE});
    b = 8'($urandom);
    peer.send(b);
    repeat (40) @(posedge clk);
    rdchk(OFS_RX_BUFFER, {24'h0, b}, 32'hFF, "rx_on");
    $display("test rx_command done");
    // transmit: write while disabled, two accepted, third refused
    fork
      begin
        peer.recv(c);
        chk("tx0", {24'h0, c}, {24'h0, txq.pop_front()});
        peer.recv(c);
        chk("tx1", {24'h0, c}, {24'h0, txq.pop_front()});
      end
      begin
        wr(OFS_TX_BUFFER, 32'h5A);
        rdchk(OFS_LINE_STATUS, 32'h0, 32'h4, "transmitter_ready_off");
        wr(OFS_COMMAND, 32'h4);
        for (int i = 0; i < 3; i++) begin
          rdchk(OFS_LINE_STATUS, (i < 2) ? 32'h4 : 32'h0, 32'h4, "transmitter_ready");
          b = 8'($urandom);
          if (i < 2) txq.push_back(b);
          wr(OFS_TX_BUFFER, {24'h0, b});
          // let the shift register take the character
          repeat (4) @(posedge clk);
        end
        rdchk(OFS_LINE_STATUS, 32'h0, 32'h4, "transmitter_ready_held");
      end
    join
    rdchk(OFS_LINE_STATUS, 32'h4, 32'h4, "transmitter_ready_idle");
    $display("test tx_buffer done");
    // loop-back keeps a disabled receiver running; multidrop refuses enable
    wr(OFS_MODE, 32'h80);
    wr(OFS_COMMAND, {30'h0, CMD_DISABLE});
    b = 8'($urandom);
    wr(OFS_TX_BUFFER, {24'h0, b});
    repeat (400) @(posedge clk);
    rdchk(OFS_RX_BUFFER, {24'h0, b}, 32'hFF, "loopback");
    wr(OFS_MODE, 32'h18);
    wr(OFS_COMMAND, {30'h0, CMD_ENABLE});
    wr(OFS_MODE, 32'h0);
    b = 8'($urandom);
    peer.send(b);
    repeat (40) @(posedge clk);
    rdchk(OFS_LINE_STATUS, 32'h0, 32'h1, "md_enable");
    $display("test rx_modes done");
    // clear-to-send change routed to interrupt, then not routed
    wr(OFS_AUX_CONTROL, 32'h1);
    wr(OFS_INT_MASK, 32'h80);
    ctsN <= 1'b0;
    repeat (60) @(posedge clk);
    chk("irq_cos", {31'h0, irq}, 32'h1);
    rdchk(OFS_INPUT_CHANGE, 32'h10, 32'hFF, "ipc_low");
    rdchk(OFS_INT_STATUS, 32'h0, 32'h80, "isr_clr");
    chk("irq_clr", {31'h0, irq}, 32'h0);
    ctsN <= 1'b1;
    repeat (5) @(posedge clk);
    ctsN <= 1'b0;
    repeat (60) @(posedge clk);
    rdchk(OFS_INPUT_CHANGE, 32'h00, 32'hFF, "ipc_glitch");
    wr(OFS_AUX_CONTROL, 32'h0);
    ctsN <= 1'b1;
    repeat (60) @(posedge clk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    rdchk(OFS_INT_STATUS, 32'h0, 32'h80, "isr_off");
    rdchk(OFS_INPUT_CHANGE, 32'h11, 32'hFF, "ipc_high");
    $display("test cts_change done");
    // reset in mid-run with clear-to-send asserted
    ctsN <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk("irq_rst2", {31'h0, irq}, 32'h0);
    rdchk(OFS_INPUT_CHANGE, 32'h10, 32'hFF, "ipc_start");
    $display("test cts_start done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: tb/urb_serial_peer.sv
// remote serial device: drives the receive line and captures the transmit line
`default_nettype none
module urb_serial_peer #(
  parameter int BIT_CYC = 32
) (
  input  wire logic ref_clk,
  output logic      rxLine,
  input  wire logic txLine
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxLine = 1'b1;
  // 8N1 frame, lsb first; line rests high between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk) rxLine <= f[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask
  // samples each data bit at its middle
  task automatic recv(output logic [7:0] b);
    @(negedge txLine);
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = txLine;
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire
